// ===== src/xfer_ctl_pkg.sv
// Package for the interrupt-activated transfer controller
package xfer_ctl_pkg;
    // Second mode byte field positions
    localparam int MB_CHAIN_EN   = 7;
    localparam int MB_CHAIN_SEL  = 6;
    localparam int MB_IRQ_EVERY  = 5;
    localparam int MB_AREA_SIDE  = 4;
    localparam int MB_DMODE_HI   = 3;
    localparam int MB_DMODE_LO   = 2;
    // First mode byte size field positions
    localparam int MA_SIZE_HI    = 5;
    localparam int MA_SIZE_LO    = 4;
    // Data size codes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;
    // Destination mode codes
    localparam logic [1:0] DMODE_INC = 2'h2;
    localparam logic [1:0] DMODE_DEC = 2'h3;
    // Descriptor word offsets in bytes
    localparam logic [31:0] DESC_W0   = 32'h0000_0000;
    localparam logic [31:0] DESC_W1   = 32'h0000_0004;
    localparam logic [31:0] DESC_W2   = 32'h0000_0008;
    localparam logic [31:0] DESC_W3   = 32'h0000_000C;
    localparam logic [31:0] DESC_SHORT_LEN = 32'h0000_000C;
    localparam logic [31:0] DESC_FULL_LEN  = 32'h0000_0010;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic        chain_enable;
        logic        chain_condition_select;
        logic        irq_every_transfer_select;
        logic        area_side_select;
        logic [1:0]  dest_mode;
        logic [1:0]  reserved;
    } transfer_mode_b_t;

    // Bus request carrier
    typedef struct packed {
        logic        write;
        logic [31:0] addr;
        logic [1:0]  size;
        logic [31:0] wdata;
    } bus_req_t;

    // Step of a pointer for a data size
    function automatic logic [31:0] size_step(input logic [1:0] sz);
        return (sz == SIZE_LONG) ? 32'h0000_0004 :
               (sz == SIZE_WORD) ? 32'h0000_0002 : 32'h0000_0001;
    endfunction

    // Sign fill from bit 23 in short address mode
    function automatic logic [31:0] eff_addr(input logic [31:0] p, input logic full);
        return full ? p : {{8{p[23]}}, p[23:0]};
    endfunction

    // Largest aligned piece that fits at address with bytes left
    function automatic logic [1:0] piece(input logic [1:0] a, input logic [2:0] left);
        if (a == 2'h0 && left >= 3'h4) return SIZE_LONG;
        if (a[0] == 1'b0 && left >= 3'h2) return SIZE_WORD;
        return SIZE_BYTE;
    endfunction
endpackage

// ===== src/xfer_fifo.sv
// Parameterised valid/ready FIFO for the request stream
`timescale 1ns/10ps
module xfer_fifo #(
    parameter int WIDTH = 67,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // Honest full and empty from the occupancy count
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rp_q];

    // Storage array, no reset needed
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop)  rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // xfer_fifo

// ===== src/xfer_ctl.sv
// Descriptor-driven transfer engine: mode byte B, pointers, bus split
// Summary of operation
// R1 - Chain enable bit starts next descriptor
// R2 - Chain condition: always, or count zero
// R3 - Chained transfer skips count check, no clear
// R4 - Interrupt select one: irq every transfer
// R5 - Interrupt select zero: irq at count end
// R6 - Area side: 0 destination, 1 source (held in mode_b_q here, drives no logic or output)
// R7 - Dest mode 0X: fixed, writeback skipped
// R8 - Dest mode 10: increment by size
// R9 - Dest mode 11: decrement by size
// R10 - Software writes reserved low bits zero
// R11 - Full mode uses all 32 bits
// R12 - Short mode sign-fills source from bit 23
// R13 - Short mode sign-fills destination likewise
// R14 - Misaligned source read is split
// R15 - Misaligned destination write is split
// R16 - Mode and pointers live only in memory
// R17 - Size 00 byte, 01 word, 10 long
// R18 - Fetch descriptor, transfer, write back
// R19 - Descriptor three or four longwords
// R20 - Splits aligned, ascending, exact bytes
`timescale 1ns/10ps
module xfer_ctl
    import xfer_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // Activation and configuration
    input  wire logic        act_req,
    input  wire logic [31:0] desc_addr,
    input  wire logic        full_addr_mode,
    // Count state from the counter block
    input  wire logic        count_zero,
    // Memory bus, requests
    output xfer_ctl_pkg::bus_req_t bus_req,
    output logic             bus_valid,
    input  wire logic        bus_ready,
    // Memory bus, answers
    input  wire logic        bus_rvalid,
    input  wire logic [31:0] bus_rdata,
    // Outcome
    output logic             cpu_irq,
    output logic             clear_source,
    output logic             busy,
    output logic             size_error
);
    logic rs1_q, rst_n;
    // Reset release through two flops
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) {rst_n, rs1_q} <= 2'b00;
        else         {rst_n, rs1_q} <= {rs1_q, 1'b1};
    end

    typedef enum logic [3:0] {
        ST_IDLE, ST_FETCH, ST_FWAIT, ST_RD, ST_RWAIT, ST_WR, ST_WB, ST_DONE
    } state_t;
    state_t           st_q;
    logic [31:0]      base_q;
    logic [1:0]       widx_q;
    logic [1:0]       drain_q;
    logic [7:0]       mode_a_q;
    transfer_mode_b_t mode_b_q;
    logic [31:0]      src_q, dst_q;
    logic [31:0]      data_q;
    logic [2:0]       left_q;
    logic [31:0]      off_q;
    logic             cpu_irq_q, clear_q, err_q;

    // Request fifo between engine and bus
    bus_req_t push_req;
    logic     push_valid, push_ready, fifo_empty_n;
    xfer_fifo #(.WIDTH($bits(bus_req_t)), .DEPTH(FIFO_DEPTH)) u_xfer_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_req),
        .out_valid (fifo_empty_n),
        .out_ready (bus_ready),
        .out_data  (bus_req)
    );
    assign bus_valid = fifo_empty_n;

    // Decoded descriptor fields
    wire [1:0]  dsize    = {mode_a_q[MA_SIZE_HI], mode_a_q[MA_SIZE_LO]};
    wire [2:0]  nbytes   = (dsize == SIZE_LONG) ? 3'h4 : (dsize == SIZE_WORD) ? 3'h2 : 3'h1;
    wire [31:0] step     = size_step(dsize);
    wire [2:0]  last_w   = full_addr_mode ? 3'h3 : 3'h2;
    // R11 full width pointers / R12 source sign fill
    wire [31:0] src_eff  = eff_addr(src_q, full_addr_mode);
    // R13 destination sign fill
    wire [31:0] dst_eff  = eff_addr(dst_q, full_addr_mode);
    wire        is_wr    = (st_q == ST_WR);
    wire [31:0] cur_addr = (is_wr ? dst_eff : src_eff) + off_q;
    // R14 R15 R20 aligned ascending pieces
    wire [1:0]  pc_size  = piece(cur_addr[1:0], left_q);
    wire [2:0]  pc_bytes = (pc_size == SIZE_LONG) ? 3'h4 :
                           (pc_size == SIZE_WORD) ? 3'h2 : 3'h1;
    wire [4:0]  sh       = 5'(off_q[1:0]) << 3;
    wire [31:0] wr_piece = data_q >> sh;
    // R2 chain condition / R1 chain enable
    wire        chain    = mode_b_q.chain_enable &&
                           (!mode_b_q.chain_condition_select || count_zero);
    // R7 fixed destination
    wire        dst_fix  = !mode_b_q.dest_mode[1];
    // R8 R9 destination step
    wire [31:0] dst_next = (mode_b_q.dest_mode == DMODE_DEC) ? dst_q - step :
                           (mode_b_q.dest_mode == DMODE_INC) ? dst_q + step : dst_q;
    // Descriptor word index for writeback: 1 source, 2 destination
    wire [31:0] wb_word  = (widx_q == 2'h1) ? src_q : dst_next;
    wire [31:0] wb_off   = (widx_q == 2'h1) ? DESC_W1 : DESC_W2;

    // Request steering into the fifo
    always_comb begin
        push_valid = 1'b0;
        push_req   = '0;
        unique case (st_q)
            ST_FETCH: begin
                push_valid = 1'b1;
                push_req   = '{write: 1'b0, addr: base_q + off_q, size: SIZE_LONG, wdata: '0};
            end
            ST_RD: begin
                push_valid = 1'b1;
                push_req   = '{write: 1'b0, addr: cur_addr, size: pc_size, wdata: '0};
            end
            ST_WR: begin
                push_valid = 1'b1;
                push_req   = '{write: 1'b1, addr: cur_addr, size: pc_size, wdata: wr_piece};
            end
            ST_WB: begin
                push_valid = 1'b1;
                push_req   = '{write: 1'b1, addr: base_q + wb_off, size: SIZE_LONG,
                               wdata: wb_word};
            end
            default: ;
        endcase
    end

    // Sequencer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            {base_q, off_q, src_q, dst_q, data_q} <= '0;
            {widx_q, drain_q, left_q, mode_a_q} <= '0;
            mode_b_q <= '0;
            {cpu_irq_q, clear_q, err_q} <= 3'b000;
        end else begin
            cpu_irq_q <= 1'b0;
            clear_q   <= 1'b0;
            unique case (st_q)
                ST_IDLE: if (act_req) begin
                    // R18 start from descriptor address
                    base_q <= desc_addr;
                    off_q  <= '0;
                    widx_q <= '0;
                    st_q   <= ST_FETCH;
                end
                ST_FETCH: if (push_ready) st_q <= ST_FWAIT;
                ST_FWAIT: if (bus_rvalid) begin
                    // R16 mode and pointers loaded only from memory
                    unique case (widx_q)
                        2'h0: {mode_a_q, mode_b_q} <= bus_rdata[31:16];
                        2'h1: src_q <= bus_rdata;
                        2'h2: dst_q <= bus_rdata;
                        default: ;
                    endcase
                    // R19 three or four longwords
                    if (3'(widx_q) == last_w) begin
                        off_q  <= '0;
                        left_q <= nbytes;
                        data_q <= '0;
                        // R17 size 11 is refused
                        if (dsize == 2'h3) begin
                            err_q <= 1'b1;
                            st_q  <= ST_IDLE;
                        end else st_q <= ST_RD;
                    end else begin
                        widx_q <= widx_q + 1'b1;
                        off_q  <= off_q + DESC_W1;
                        st_q   <= ST_FETCH;
                    end
                end
                ST_RD: if (push_ready) begin
                    drain_q <= pc_size;
                    st_q    <= ST_RWAIT;
                end
                ST_RWAIT: if (bus_rvalid) begin
                    data_q <= data_q | (bus_rdata << sh);
                    off_q  <= off_q + 32'(pc_bytes);
                    left_q <= left_q - pc_bytes;
                    if (left_q == pc_bytes) begin
                        off_q  <= '0;
                        left_q <= nbytes;
                        st_q   <= ST_WR;
                    end else st_q <= ST_RD;
                end
                ST_WR: if (push_ready) begin
                    off_q  <= off_q + 32'(pc_bytes);
                    left_q <= left_q - pc_bytes;
                    if (left_q == pc_bytes) begin
                        widx_q <= 2'h1;
                        st_q   <= ST_WB;
                    end
                end
                ST_WB: if (push_ready) begin
                    // R7 skip destination writeback when fixed
                    if (widx_q == 2'h1 && !dst_fix) widx_q <= 2'h2;
                    else begin
                        if (!dst_fix) dst_q <= dst_next;
                        st_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // R1 R3 chain: no count check, no clearing
                    if (chain) begin
                        base_q <= base_q + (full_addr_mode ? DESC_FULL_LEN : DESC_SHORT_LEN);
                        off_q  <= '0;
                        widx_q <= '0;
                        st_q   <= ST_FETCH;
                    end else begin
                        // R4 every transfer / R5 at count end
                        cpu_irq_q <= mode_b_q.irq_every_transfer_select || count_zero;
                        clear_q   <= mode_b_q.irq_every_transfer_select || count_zero;
                        st_q      <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    // R6 area side is held in mode_b_q and drives no logic or output here
    // R10 reserved bits are not interpreted

    assign cpu_irq      = cpu_irq_q;
    assign clear_source = clear_q;
    assign busy         = (st_q != ST_IDLE);
    assign size_error   = err_q;

    // R4 irq only out of done state
    property p_irq_cause;
        @(posedge clock) disable iff (!rst_n)
        cpu_irq |-> $past(st_q == ST_DONE) && !$past(chain);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without end"); // R4
    // R5 no irq when count left and select zero
    property p_irq_count;
        @(posedge clock) disable iff (!rst_n)
        (st_q == ST_DONE && !chain && !mode_b_q.irq_every_transfer_select && !count_zero)
            |=> !cpu_irq;
    endproperty
    a_irq_count: assert property (p_irq_count) else $error("early irq"); // R5
    // R3 chain does not clear source
    property p_chain_noclr;
        @(posedge clock) disable iff (!rst_n)
        (st_q == ST_DONE && chain) |=> !clear_source && st_q == ST_FETCH;
    endproperty
    a_chain_noclr: assert property (p_chain_noclr) else $error("chain cleared"); // R3
    // R20 pieces aligned
    property p_aligned;
        @(posedge clock) disable iff (!rst_n)
        (push_valid && (st_q == ST_RD || st_q == ST_WR)) |->
            (push_req.size == SIZE_BYTE) || (push_req.size == SIZE_WORD && !push_req.addr[0])
            || (push_req.addr[1:0] == 2'h0);
    endproperty
    a_aligned: assert property (p_aligned) else $error("misaligned piece"); // R20
    // R12 short mode source sign fill
    property p_short_src;
        @(posedge clock) disable iff (!rst_n)
        (!full_addr_mode && st_q == ST_RD) |->
            push_req.addr == {{8{src_q[23]}}, src_q[23:0]} + off_q;
    endproperty
    a_short_src: assert property (p_short_src) else $error("no sign fill"); // R12
    // R11 full mode uses pointer unchanged
    property p_full;
        @(posedge clock) disable iff (!rst_n)
        (full_addr_mode && st_q == ST_WR) |-> push_req.addr == dst_q + off_q;
    endproperty
    a_full: assert property (p_full) else $error("full addr altered"); // R11
    // R7 fixed destination keeps pointer
    property p_fixed;
        @(posedge clock) disable iff (!rst_n)
        (st_q == ST_WB && dst_fix) |=> $stable(dst_q);
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed dest moved"); // R7
    // R8 increment by step
    property p_inc;
        @(posedge clock) disable iff (!rst_n)
        (st_q == ST_WB && push_ready && widx_q == 2'h2 && mode_b_q.dest_mode == DMODE_INC)
            |=> dst_q == $past(dst_q) + $past(step);
    endproperty
    a_inc: assert property (p_inc) else $error("bad increment"); // R8
    // R9 decrement by step
    property p_dec;
        @(posedge clock) disable iff (!rst_n)
        (st_q == ST_WB && push_ready && widx_q == 2'h2 && mode_b_q.dest_mode == DMODE_DEC)
            |=> dst_q == $past(dst_q) - $past(step);
    endproperty
    a_dec: assert property (p_dec) else $error("bad decrement"); // R9

    c_chain: cover property (@(posedge clock) st_q == ST_DONE && chain);
    c_irq:   cover property (@(posedge clock) cpu_irq);
    c_split: cover property (@(posedge clock) st_q == ST_RWAIT ##1 st_q == ST_RD);
endmodule // xfer_ctl

// ===== bench/mem_model.sv
// Behavioural memory on the far side of the transfer engine's request bus
`timescale 1ns/10ps
module mem_model
    import xfer_ctl_pkg::*;
(
    // Clock and pacing
    input  wire logic              clock,
    input  wire logic              slow,
    // Request side
    input  xfer_ctl_pkg::bus_req_t bus_req,
    input  wire logic              bus_valid,
    output logic                   bus_ready,
    // Read answers
    output logic                   bus_rvalid,
    output logic [31:0]            bus_rdata
);
    import xfer_ctl_pkg::*;

    logic [7:0] mem [logic [31:0]];
    bus_req_t   log[$];
    bus_req_t   rq[$];
    bus_req_t   head;
    logic       tick = 1'b0;

    initial begin
        bus_ready  = 1'b1;
        bus_rvalid = 1'b0;
        bus_rdata  = 32'h0000_0000;
    end

    // Unwritten bytes read as a fixed filler
    function automatic logic [7:0] rdb(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : 8'hA5;
    endfunction

    // Bytes of one access, little-endian, right-justified
    function automatic logic [31:0] rd(input bus_req_t r);
        logic [31:0] v;
        v = 32'h0000_0000;
        for (int i = 0; i < int'(size_step(r.size)); i++) begin
            v[8*i+:8] = rdb(r.addr + i);
        end
        return v;
    endfunction

    // Accept, store writes, answer reads in order; slow mode stalls every other cycle
    always @(posedge clock) begin
        if (bus_valid === 1'b1 && bus_ready) begin
            log.push_back(bus_req);
            if (bus_req.write) begin
                for (int i = 0; i < int'(size_step(bus_req.size)); i++) begin
                    mem[bus_req.addr + i] = bus_req.wdata[8*i+:8];
                end
            end else begin
                rq.push_back(bus_req);
            end
        end
        if (rq.size() > 0 && (!slow || tick)) begin
            head = rq.pop_front();
            bus_rvalid <= 1'b1;
            bus_rdata  <= rd(head);
        end else begin
            // Idle data lines invert each cycle, so they hold the last answer again on every second idle cycle
            bus_rvalid <= 1'b0;
            bus_rdata  <= ~bus_rdata;
        end
        tick      <= ~tick;
        bus_ready <= !slow || tick;
    end
endmodule // mem_model

// ===== bench/xfer_ctl_tb.sv
// Self-checking testbench for the transfer engine against a memory model
`timescale 1ns/10ps
module xfer_ctl_tb;
    import xfer_ctl_pkg::*;

    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        act_req = 1'b0;
    logic [31:0] desc_addr = 32'h0000_0000;
    logic        full_addr_mode = 1'b1;
    logic        count_zero = 1'b0;
    logic        slow = 1'b0;
    bus_req_t    bus_req;
    logic        bus_valid, bus_ready, bus_rvalid;
    logic [31:0] bus_rdata;
    logic        cpu_irq, clear_source, busy, size_error;
    int          fail_count = 0;
    int          num_checks = 0;
    int          irq_n, clear_n;

    always #10 clock = ~clock;

    xfer_ctl u_xfer_ctl (.clock(clock), .arst_n(arst_n), .act_req(act_req),
        .desc_addr(desc_addr), .full_addr_mode(full_addr_mode), .count_zero(count_zero),
        .bus_req(bus_req), .bus_valid(bus_valid), .bus_ready(bus_ready),
        .bus_rvalid(bus_rvalid), .bus_rdata(bus_rdata), .cpu_irq(cpu_irq),
        .clear_source(clear_source), .busy(busy), .size_error(size_error));

    mem_model u_mem_model (.clock(clock), .slow(slow), .bus_req(bus_req),
        .bus_valid(bus_valid), .bus_ready(bus_ready), .bus_rvalid(bus_rvalid),
        .bus_rdata(bus_rdata));

    // Pulse counters, irq and clear are one-cycle strobes
    always @(posedge clock) begin
        if (cpu_irq === 1'b1) irq_n++;
        if (clear_source === 1'b1) clear_n++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic pw(input logic [31:0] a, input logic [31:0] w);
        for (int i = 0; i < 4; i++) u_mem_model.mem[a + i] = w[8*i+:8];
    endtask

    function automatic logic [31:0] mw(input logic [31:0] a);
        return {u_mem_model.rdb(a + 3), u_mem_model.rdb(a + 2),
                u_mem_model.rdb(a + 1), u_mem_model.rdb(a)};
    endfunction

    task automatic desc(input logic [31:0] a, input logic [1:0] sz, input logic [3:0] b,
                        input logic [1:0] dm, input logic [31:0] src, input logic [31:0] dst);
        pw(a, {2'b00, sz, 4'h0, b, dm, 2'b00, 16'h0000});
        pw(a + 4, src);
        pw(a + 8, dst);
        pw(a + 12, 32'h0000_0000);
    endtask

    // Written value at an address in this run's log; all ones when never written
    function automatic logic [31:0] wb(input logic [31:0] a);
        foreach (u_mem_model.log[i])
            if (u_mem_model.log[i].write && u_mem_model.log[i].addr == a)
                return u_mem_model.log[i].wdata;
        return 32'hFFFF_FFFF;
    endfunction

    function automatic logic [31:0] entry(input int i);
        if (i >= u_mem_model.log.size()) return 32'hFFFF_FFFF;
        return {u_mem_model.log[i].write, u_mem_model.log[i].size, u_mem_model.log[i].addr[28:0]};
    endfunction

    // One activation, bounded waits for start and for return to idle
    task automatic run(input logic [31:0] d, input logic full, input logic cz);
        int n;
        u_mem_model.log.delete();
        irq_n = 0;
        clear_n = 0;
        @(negedge clock);
        desc_addr = d;
        full_addr_mode = full;
        count_zero = cz;
        act_req = 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        act_req = 1'b0;
        if (n >= 50) begin
            fail_count++;
            give_verdict();
        end
        // Posted writes may still sit in the request fifo after idle
        while ((busy !== 1'b0 || bus_valid !== 1'b0) && n < 2000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 2000) begin
            fail_count++;
            give_verdict();
        end
        repeat (2) @(negedge clock);
    endtask

    initial begin
        repeat (5) @(negedge clock);
        arst_n = 1'b1;
        repeat (4) @(negedge clock);

        // Full mode, long read from 4n+2 is split, irq every transfer
        pw(32'h0000_0102, 32'h4433_2211);
        desc(32'h0000_0000, SIZE_LONG, 4'b0010, DMODE_INC, 32'h0000_0102, 32'h0000_0200);
        run(32'h0000_0000, 1'b1, 1'b0);
        check(entry(4), {1'b0, SIZE_WORD, 29'h0000_0102});
        check(entry(5), {1'b0, SIZE_WORD, 29'h0000_0104});
        check(entry(6), {1'b1, SIZE_LONG, 29'h0000_0200});
        check(mw(32'h0000_0200), 32'h4433_2211);
        check(wb(32'h0000_0008), 32'h0000_0204);
        check(irq_n, 1);
        check(size_error, 1'b0);
        $display("Test aligned split done");

        // Short mode, sign fill, odd word write split, slow memory, irq at count end
        slow = 1'b1;
        pw(32'hFF80_0010, 32'h0000_BBAA);
        desc(32'h0000_0100, SIZE_WORD, 4'b0000, DMODE_DEC, 32'h5A80_0010, 32'h3380_0021);
        run(32'h0000_0100, 1'b0, 1'b1);
        slow = 1'b0;
        check(entry(3), {1'b0, SIZE_WORD, 29'h1F80_0010});
        check(entry(4), {1'b1, SIZE_BYTE, 29'h1F80_0021});
        check(entry(5), {1'b1, SIZE_BYTE, 29'h1F80_0022});
        check(u_mem_model.log[4].addr, 32'hFF80_0021);
        check(wb(32'h0000_0108), 32'h3380_001F);
        check(mw(32'hFF80_0021) & 32'h0000_FFFF, 32'h0000_BBAA);
        check(irq_n, 1);
        $display("Test short mode done");

        // Fixed destination, count not at zero: no destination writeback, no irq
        desc(32'h0000_0040, SIZE_BYTE, 4'b0000, 2'h0, 32'h0000_0300, 32'h0000_0310);
        run(32'h0000_0040, 1'b1, 1'b0);
        check(wb(32'h0000_0048), 32'hFFFF_FFFF);
        check(irq_n, 0);
        check(clear_n, 0);
        $display("Test fixed destination done");

        // Chain every time into a second descriptor with irq every transfer
        pw(32'h0000_0300, 32'h0000_7766);
        desc(32'h0000_0400, SIZE_BYTE, 4'b1000, DMODE_INC, 32'h0000_0300, 32'h0000_0310);
        desc(32'h0000_0410, SIZE_BYTE, 4'b0010, DMODE_INC, 32'h0000_0301, 32'h0000_0311);
        run(32'h0000_0400, 1'b1, 1'b0);
        check(mw(32'h0000_0310) & 32'h0000_FFFF, 32'h0000_7766);
        check(irq_n, 1);
        check(clear_n, 1);
        $display("Test chain every time done");

        // Chain only at count zero, count not zero: second descriptor untouched
        desc(32'h0000_0500, SIZE_BYTE, 4'b1100, DMODE_INC, 32'h0000_0300, 32'h0000_0330);
        desc(32'h0000_0510, SIZE_BYTE, 4'b0010, DMODE_INC, 32'h0000_0300, 32'h0000_0340);
        run(32'h0000_0500, 1'b1, 1'b0);
        check(u_mem_model.rdb(32'h0000_0340), 8'hA5);
        check(u_mem_model.rdb(32'h0000_0330), 8'h66);
        check(irq_n, 0);
        $display("Test chain at count zero done");

        // Prohibited size: flagged, nothing written
        desc(32'h0000_0600, 2'h3, 4'b0010, DMODE_INC, 32'h0000_0300, 32'h0000_0350);
        run(32'h0000_0600, 1'b1, 1'b1);
        check(size_error, 1'b1);
        check(u_mem_model.rdb(32'h0000_0350), 8'hA5);
        $display("Test prohibited size done");
        give_verdict();
    end
endmodule // xfer_ctl_tb
